// ### rtl/e1tx_formatter.sv
// E1 transmit formatter control for one port plus its register file.
// Assumes an external LIU on the line outputs, clocks sampled by sys_clk.
`timescale 1ns/10ps
module e1tx_formatter #(
    parameter logic [2:0] PORT_ID = 3'h0,
    parameter int CRC_SHORT_CYCLES = e1tx_pkg::CRC_SYNC_SHORT_MS * e1tx_pkg::SYS_CLK_MHZ * 1000,
    parameter int CRC_LONG_CYCLES = e1tx_pkg::CRC_SYNC_LONG_MS * e1tx_pkg::SYS_CLK_MHZ * 1000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Line side pins
    input wire logic tx_line_clock,
    input wire logic rx_line_clock,
    input wire logic tx_serial_in,
    input wire logic tx_frame_sync_pin,
    input wire logic tx_system_sync_pin,
    // Receive side alarms and latched status interrupt requests
    input wire logic [3:0] rx_alarm_in,
    input wire logic [2:0] status_irq_in,
    // Line outputs and configuration levels
    output logic line_out_positive,
    output logic line_out_negative,
    output logic tx_channel_block_out,
    output logic send_remote_alarm,
    output logic auto_ebit_active,
    output logic crc_gen_active,
    output logic crc_recalc_active,
    output logic ts16_from_regs,
    output logic si_from_regs,
    output logic ts0_internal,
    output logic mf_ref_system,
    output logic processor_reset,
    output logic line_standard_e1
);
    localparam int CNT_W = 32;

    // Elaboration guard: the short timeout must be nonzero and come first
    if (CRC_SHORT_CYCLES < 1 || CRC_LONG_CYCLES <= CRC_SHORT_CYCLES)
    begin
        $error("Bad CRC sync timeout parameters");
    end

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [3:0] al1;
        logic [3:0] al2;
        e1tx_pkg::e1tx_port_cfg_t cfg;
        e1tx_pkg::e1tx_state_t state;
        logic [7:0] rdata;
        logic [2:0] summary;
        logic clk_prev;
        logic [15:0] idle_cnt;
        logic use_rx;
        logic [7:0] bit_pos;
        logic [1:0] ones_run;
        logic bpv_armed;
        logic bpv_prev;
        logic last_pol;
        logic half;
        logic [CNT_W-1:0] crc_cnt;
        logic pos;
        logic neg;
        logic chblk;
        logic rai;
        logic ts0_int;
        logic held;
    } e1tx_state_s_t;

    e1tx_state_s_t q, d;
    // Kept apart from the state struct: it is reset by the pin, the rest by its copy
    logic [1:0] rst_sync_q;
    logic rst_n_int;
    assign rst_n_int = rst_sync_q[1];

    // Register offset within one port window
    function automatic logic [8:0] reg_index(input logic [11:0] a);
        reg_index = a[8:0];
    endfunction

    function automatic logic addr_hit(input logic [11:0] a, input logic [8:0] r);
        addr_hit = (reg_index(a) == r) && (a[11:9] == PORT_ID);
    endfunction

    // Reset release synchroniser; only its last stage resets the logic
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // Main state register
    always_ff @(posedge sys_clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            q.s1 <= '0;
            q.s2 <= '0;
            q.al1 <= '0;
            q.al2 <= '0;
            q.cfg <= '0;
            q.state <= e1tx_pkg::ST_SLEEP;
            q.rdata <= e1tx_pkg::RESET_VALUE;
            q.summary <= '0;
            q.clk_prev <= 1'b0;
            q.idle_cnt <= '0;
            q.use_rx <= 1'b0;
            q.bit_pos <= '0;
            q.ones_run <= '0;
            q.bpv_armed <= 1'b0;
            q.bpv_prev <= 1'b0;
            q.last_pol <= 1'b0;
            q.half <= 1'b0;
            q.crc_cnt <= '0;
            q.pos <= 1'b0;
            q.neg <= 1'b0;
            q.chblk <= 1'b0;
            q.rai <= 1'b0;
            q.ts0_int <= 1'b1;
            q.held <= 1'b0;
        end
        else
        begin
            q.s1 <= d.s1;
            q.s2 <= d.s2;
            q.al1 <= d.al1;
            q.al2 <= d.al2;
            q.cfg <= d.cfg;
            q.state <= d.state;
            q.rdata <= d.rdata;
            q.summary <= d.summary;
            q.clk_prev <= d.clk_prev;
            q.idle_cnt <= d.idle_cnt;
            q.use_rx <= d.use_rx;
            q.bit_pos <= d.bit_pos;
            q.ones_run <= d.ones_run;
            q.bpv_armed <= d.bpv_armed;
            q.bpv_prev <= d.bpv_prev;
            q.last_pol <= d.last_pol;
            q.half <= d.half;
            q.crc_cnt <= d.crc_cnt;
            q.pos <= d.pos;
            q.neg <= d.neg;
            q.chblk <= d.chblk;
            q.rai <= d.rai;
            q.ts0_int <= d.ts0_int;
            q.held <= d.held;
        end
    end

    // Next-state logic
    always_comb
    begin
        logic clk_now;
        logic clk_rise;
        logic running;
        logic ais;
        logic rx_fault;
        logic data_bit;
        logic mark;
        logic [1:0] src;
        clk_now = 1'b0;
        clk_rise = 1'b0;
        running = 1'b0;
        ais = 1'b0;
        rx_fault = 1'b0;
        data_bit = 1'b0;
        mark = 1'b0;
        src = 2'h0;
        d = q;
        // Two-stage sampling of pins: clocks, data, syncs
        d.s1 = {tx_line_clock, rx_line_clock, tx_serial_in, tx_frame_sync_pin,
            tx_system_sync_pin};
        d.s2 = q.s1;
        d.al1 = rx_alarm_in;
        d.al2 = q.al1;

        // Register writes; unused bits are stored as zero
        if (reg_wr)
        begin
            if (addr_hit(reg_addr, e1tx_pkg::REG_MASTER_MODE))
                d.cfg.master = reg_wdata & e1tx_pkg::MM_WRITE_MASK;
            if (addr_hit(reg_addr, e1tx_pkg::REG_CONTROL_ONE))
                d.cfg.ctl_one = reg_wdata;
            if (addr_hit(reg_addr, e1tx_pkg::REG_CONTROL_TWO))
                d.cfg.ctl_two = reg_wdata & e1tx_pkg::C2_WRITE_MASK;
            if (addr_hit(reg_addr, e1tx_pkg::REG_CONTROL_THREE))
                d.cfg.ctl_three = reg_wdata & e1tx_pkg::C3_WRITE_MASK;
        end

        // Summary follows latched status sources, clearing when they clear
        d.summary = status_irq_in;

        // Read data, valid in the cycle after the strobe only
        d.rdata = 8'h00;
        if (reg_rd && reg_addr[11:9] == PORT_ID)
        begin
            case (reg_index(reg_addr))
                e1tx_pkg::REG_MASTER_MODE: d.rdata = q.cfg.master;
                e1tx_pkg::REG_CONTROL_ONE: d.rdata = q.cfg.ctl_one;
                e1tx_pkg::REG_CONTROL_TWO: d.rdata = q.cfg.ctl_two;
                e1tx_pkg::REG_CONTROL_THREE: d.rdata = q.cfg.ctl_three;
                e1tx_pkg::REG_INT_SUMMARY: d.rdata = {5'h00, q.summary};
                e1tx_pkg::REG_LINE_STATUS: d.rdata = {3'h0, q.use_rx, q.state};
                default: d.rdata = 8'h00;
            endcase
        end

        // Init sequence: soft reset holds, init done then checks enable
        case (q.state)
            e1tx_pkg::ST_SLEEP:
                if (q.cfg.master[e1tx_pkg::MM_SOFT_RESET])
                    d.state = e1tx_pkg::ST_HELD;
                else if (q.cfg.master[e1tx_pkg::MM_INIT_DONE]
                    && q.cfg.master[e1tx_pkg::MM_FRAMER_EN])
                    d.state = e1tx_pkg::ST_RUN;
            e1tx_pkg::ST_HELD:
                if (!q.cfg.master[e1tx_pkg::MM_SOFT_RESET])
                    d.state = e1tx_pkg::ST_WAIT_INIT;
            e1tx_pkg::ST_WAIT_INIT:
                if (q.cfg.master[e1tx_pkg::MM_SOFT_RESET])
                    d.state = e1tx_pkg::ST_HELD;
                else if (q.cfg.master[e1tx_pkg::MM_INIT_DONE])
                    d.state = q.cfg.master[e1tx_pkg::MM_FRAMER_EN]
                        ? e1tx_pkg::ST_RUN : e1tx_pkg::ST_SLEEP;
            e1tx_pkg::ST_RUN:
                if (q.cfg.master[e1tx_pkg::MM_SOFT_RESET])
                    d.state = e1tx_pkg::ST_HELD;
                else if (!q.cfg.master[e1tx_pkg::MM_FRAMER_EN])
                    d.state = e1tx_pkg::ST_SLEEP;
            default: d.state = e1tx_pkg::ST_SLEEP;
        endcase
        running = (q.state == e1tx_pkg::ST_RUN);
        d.held = (d.state == e1tx_pkg::ST_HELD);
        d.ts0_int = !d.cfg.ctl_one[e1tx_pkg::C1_TS0_PASS];

        // Clock source selection with loss-of-clock fallback
        src = {q.cfg.ctl_three[e1tx_pkg::C3_CLK_HI], q.cfg.ctl_three[e1tx_pkg::C3_CLK_LO]};
        if (q.s2[4] != q.clk_prev)
            d.idle_cnt = '0;
        else if (q.idle_cnt < 16'(e1tx_pkg::CHANNEL_CYCLES))
            d.idle_cnt = q.idle_cnt + 16'h0001;
        case (src)
            e1tx_pkg::CLK_SRC_RX: d.use_rx = 1'b1;
            e1tx_pkg::CLK_SRC_AUTO:
                d.use_rx = (q.idle_cnt >= 16'(e1tx_pkg::CHANNEL_CYCLES));
            default: d.use_rx = 1'b0;
        endcase
        clk_now = q.use_rx ? q.s2[3] : q.s2[4];
        d.clk_prev = q.s2[4];
        clk_rise = clk_now && !q.half && running;

        // CRC multiframe search timer, started by loss of frame clearing
        if (q.al2[3])
            d.crc_cnt = '0;
        else if (!q.al2[3] && q.crc_cnt < CNT_W'(CRC_LONG_CYCLES))
            d.crc_cnt = q.crc_cnt + 32'h0000_0001;
        rx_fault = q.al2[3] | q.al2[2] | q.al2[1];
        // Remote alarm: faults, or CRC sync missing past the short timeout
        d.rai = running && q.cfg.ctl_two[e1tx_pkg::C2_AUTO_RAI]
            && (rx_fault || (q.cfg.ctl_one[e1tx_pkg::C1_CRC4] && !q.al2[0]
            && q.crc_cnt >= CNT_W'(CRC_SHORT_CYCLES)));
        ais = q.cfg.ctl_one[e1tx_pkg::C1_AIS]
            || (q.cfg.ctl_two[e1tx_pkg::C2_AUTO_AIS] && rx_fault);

        // Bit timing and line coding on the chosen clock edge
        d.half = clk_now;
        // Half-width pulses return to zero while the chosen clock is low
        if (!clk_now && q.cfg.ctl_three[e1tx_pkg::C3_PULSE_MODE])
        begin
            d.pos = 1'b0;
            d.neg = 1'b0;
        end
        d.bpv_prev = q.cfg.ctl_three[e1tx_pkg::C3_INS_BPV];
        if (q.cfg.ctl_three[e1tx_pkg::C3_INS_BPV] && !q.bpv_prev)
            d.bpv_armed = 1'b1;
        if (clk_rise)
        begin
            d.bit_pos = q.bit_pos + 8'h01;
            data_bit = q.s2[2];
            if (q.cfg.ctl_one[e1tx_pkg::C1_SIG_ONES] && q.bit_pos[7:3] == 5'h10)
                data_bit = 1'b1;
            if (ais)
                data_bit = 1'b1;
            d.ones_run = data_bit ? ((q.ones_run == 2'h3) ? 2'h3 : q.ones_run + 2'h1) : 2'h0;
            mark = data_bit;
            if (q.cfg.ctl_three[e1tx_pkg::C3_DATA_FMT])
            begin
                d.pos = data_bit;
                d.neg = 1'b0;
            end
            else if (mark)
            begin
                // Violation repeats the last polarity on the third one
                if (q.bpv_armed && q.ones_run == 2'h2)
                begin
                    d.bpv_armed = 1'b0;
                    d.last_pol = q.last_pol;
                end
                else
                    d.last_pol = !q.last_pol;
                d.pos = !d.last_pol;
                d.neg = d.last_pol;
            end
            else
            begin
                d.pos = 1'b0;
                d.neg = 1'b0;
            end
            d.chblk = q.cfg.ctl_one[e1tx_pkg::C1_CHAN26]
                && q.bit_pos == 8'(e1tx_pkg::TS26_BIT1);
        end
        // NRZ keeps the negative output low even when the format changes mid-bit
        if (q.cfg.ctl_three[e1tx_pkg::C3_DATA_FMT])
            d.neg = 1'b0;
        if (!running)
        begin
            d.pos = 1'b0;
            d.neg = 1'b0;
            d.chblk = 1'b0;
            d.bit_pos = '0;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = q.rdata;
    assign line_out_positive = q.pos;
    assign line_out_negative = q.neg;
    assign tx_channel_block_out = q.chblk;
    assign send_remote_alarm = q.rai;
    assign auto_ebit_active = q.cfg.ctl_two[e1tx_pkg::C2_AUTO_EBIT];
    assign crc_gen_active = q.cfg.ctl_one[e1tx_pkg::C1_CRC4];
    assign crc_recalc_active = q.cfg.ctl_three[e1tx_pkg::C3_CRC_RECALC];
    assign ts16_from_regs = q.cfg.ctl_one[e1tx_pkg::C1_TS16_SRC];
    assign si_from_regs = q.cfg.ctl_one[e1tx_pkg::C1_INTL_SEL];
    assign ts0_internal = q.ts0_int;
    assign mf_ref_system = q.cfg.ctl_three[e1tx_pkg::C3_MF_REF];
    assign processor_reset = q.held;
    assign line_standard_e1 = q.cfg.master[e1tx_pkg::MM_LINE_STD];

    // Checks
    a_sleep_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        (q.state != e1tx_pkg::ST_RUN) |=> !line_out_positive && !line_out_negative)
        else $error("Output active while asleep");
    a_held_reset: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        q.cfg.master[e1tx_pkg::MM_SOFT_RESET] |=> q.state == e1tx_pkg::ST_HELD)
        else $error("Soft reset not honoured");
    a_summary_follow: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        ##1 q.summary == $past(status_irq_in)) else $error("Summary mismatch");
    a_nrz_neg_low: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        q.cfg.ctl_three[e1tx_pkg::C3_DATA_FMT] |=> !line_out_negative)
        else $error("NRZ negative output high");
    a_bpv_single: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        $rose(q.bpv_armed) |-> $past(q.cfg.ctl_three[e1tx_pkg::C3_INS_BPV])
        && !$past(q.bpv_prev)) else $error("Violation armed without a rising insert bit");
    a_init_run: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        (q.state == e1tx_pkg::ST_WAIT_INIT && q.cfg.master[e1tx_pkg::MM_INIT_DONE]
        && q.cfg.master[e1tx_pkg::MM_FRAMER_EN] && !q.cfg.master[e1tx_pkg::MM_SOFT_RESET])
        |=> q.state == e1tx_pkg::ST_RUN) else $error("Init done ignored");
    a_clk_rx_force: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        (q.cfg.ctl_three[5:4] == e1tx_pkg::CLK_SRC_RX) |=> q.use_rx)
        else $error("Receive clock not selected");
    a_rai_gate: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
        !q.cfg.ctl_two[e1tx_pkg::C2_AUTO_RAI] |=> !send_remote_alarm)
        else $error("Remote alarm without enable");
endmodule

// ### rtl/e1tx_pkg.sv
// Package for the E1 transmit formatter control block.
// Assumes a single sys_clk domain; all users reference items as e1tx_pkg::name.
package e1tx_pkg;
    // Register indices within one port window (byte address = index)
    localparam logic [8:0] REG_MASTER_MODE = 9'h180;
    localparam logic [8:0] REG_CONTROL_ONE = 9'h181;
    localparam logic [8:0] REG_CONTROL_TWO = 9'h182;
    localparam logic [8:0] REG_CONTROL_THREE = 9'h183;
    localparam logic [8:0] REG_INT_SUMMARY = 9'h19f;
    localparam logic [8:0] REG_LINE_STATUS = 9'h1b8;
    localparam logic [8:0] PORT_MASK = 9'h1ff;
    localparam int PORT_STRIDE_SHIFT = 9;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // Master mode fields
    localparam int MM_LINE_STD = 0;
    localparam int MM_SOFT_RESET = 1;
    localparam int MM_INIT_DONE = 6;
    localparam int MM_FRAMER_EN = 7;
    localparam logic [7:0] MM_WRITE_MASK = 8'hc3;
    // Control one fields
    localparam int C1_CRC4 = 0;
    localparam int C1_AIS = 1;
    localparam int C1_HDB3 = 2;
    localparam int C1_SIG_ONES = 3;
    localparam int C1_INTL_SEL = 4;
    localparam int C1_CHAN26 = 5;
    localparam int C1_TS16_SRC = 6;
    localparam int C1_TS0_PASS = 7;
    // Control two fields
    localparam int C2_AUTO_RAI = 5;
    localparam int C2_AUTO_AIS = 6;
    localparam int C2_AUTO_EBIT = 7;
    localparam logic [7:0] C2_WRITE_MASK = 8'he0;
    // Control three fields
    localparam int C3_CRC_RECALC = 0;
    localparam int C3_INS_BPV = 1;
    localparam int C3_MF_REF = 3;
    localparam int C3_CLK_LO = 4;
    localparam int C3_CLK_HI = 5;
    localparam int C3_PULSE_MODE = 6;
    localparam int C3_DATA_FMT = 7;
    localparam logic [7:0] C3_WRITE_MASK = 8'hfb;
    // Clock source encodings
    localparam logic [1:0] CLK_SRC_TX = 2'h0;
    localparam logic [1:0] CLK_SRC_AUTO = 2'h1;
    localparam logic [1:0] CLK_SRC_RX = 2'h3;
    // Timing
    localparam int SYS_CLK_MHZ = 125;
    localparam int CHANNEL_TIME_NS = 3904;
    localparam int CHANNEL_CYCLES = (CHANNEL_TIME_NS * SYS_CLK_MHZ) / 1000;
    localparam int CRC_SYNC_SHORT_MS = 128;
    localparam int CRC_SYNC_LONG_MS = 400;
    localparam int FRAME_BITS = 256;
    localparam int TS16_FIRST = 128;
    localparam int TS26_BIT1 = 208;

    // Register bus request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } e1tx_bus_t;

    // Receive side alarm summary
    typedef struct packed {
        logic loss_frame;
        logic all_ones_in;
        logic loss_signal;
        logic crc_mf_sync;
    } e1tx_rx_alarm_t;

    // Per-port configuration
    typedef struct packed {
        logic [7:0] master;
        logic [7:0] ctl_one;
        logic [7:0] ctl_two;
        logic [7:0] ctl_three;
    } e1tx_port_cfg_t;

    typedef enum logic [3:0] {
        ST_SLEEP = 4'b0001,
        ST_HELD = 4'b0010,
        ST_WAIT_INIT = 4'b0100,
        ST_RUN = 4'b1000
    } e1tx_state_t;
endpackage

// ### tb/e1tx_liu_model.sv
// Far-side line interface model: line clocks and serial data for the formatter.
// Assumes the bench reads the line outputs itself.
`timescale 1ns/10ps
module e1tx_liu_model (
    // Clocks toward the formatter
    output logic tx_line_clock,
    output logic rx_line_clock,
    // Serial data toward the formatter
    output logic tx_serial_in
);
    // Line clocks run free at 64 ns; receive clock offset so phases are unrelated
    initial
    begin
        tx_line_clock = 1'b0;
        forever #32 tx_line_clock = ~tx_line_clock;
    end
    initial
    begin
        rx_line_clock = 1'b0;
        #13;
        forever #32 rx_line_clock = ~rx_line_clock;
    end
    // Data moves on the falling edge, away from the formatter's sampling edge
    initial tx_serial_in = 1'b0;
    always @(negedge tx_line_clock)
        tx_serial_in <= 1'($urandom_range(1));
endmodule

// ### tb/e1tx_formatter_tb.sv
// Self-checking bench for the E1 transmit formatter control block.
// Assumes the line model makes the line clocks; the bench acts as host.
`timescale 1ns/10ps
module e1tx_formatter_tb;
    localparam logic [2:0] PID = 3'h2;
    localparam logic [8:0] IDX [4] = '{e1tx_pkg::REG_MASTER_MODE, e1tx_pkg::REG_CONTROL_ONE,
        e1tx_pkg::REG_CONTROL_TWO, e1tx_pkg::REG_CONTROL_THREE};
    localparam logic [7:0] MSK [4] = '{e1tx_pkg::MM_WRITE_MASK, 8'hff,
        e1tx_pkg::C2_WRITE_MASK, e1tx_pkg::C3_WRITE_MASK};
    logic sys_clk, reset_n, reg_wr, reg_rd;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_v, v;
    logic tx_line_clock, rx_line_clock, tx_serial_in;
    logic [3:0] rx_alarm_in;
    logic [2:0] status_irq_in;
    logic line_out_positive, line_out_negative, tx_channel_block_out, send_remote_alarm;
    logic auto_ebit_active, crc_gen_active, crc_recalc_active, ts16_from_regs;
    logic si_from_regs, ts0_internal, mf_ref_system, processor_reset, line_standard_e1;
    logic [7:0] cfg [4];
    logic hit;
    int mismatches, n_compared;

    // Short CRC timeouts keep the run brief
    e1tx_formatter #(.PORT_ID(PID), .CRC_SHORT_CYCLES(200), .CRC_LONG_CYCLES(400))
        e1tx_formatter_inst (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .tx_line_clock, .rx_line_clock, .tx_serial_in,
        .tx_frame_sync_pin(1'b0), .tx_system_sync_pin(1'b0), .rx_alarm_in, .status_irq_in,
        .line_out_positive, .line_out_negative, .tx_channel_block_out, .send_remote_alarm,
        .auto_ebit_active, .crc_gen_active, .crc_recalc_active, .ts16_from_regs,
        .si_from_regs, .ts0_internal, .mf_ref_system, .processor_reset, .line_standard_e1);

    e1tx_liu_model e1tx_liu_model_inst (.tx_line_clock, .rx_line_clock, .tx_serial_in);

    // System clock, 8 ns
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One-cycle write strobe; a gap cycle follows so strobes never double up
    task automatic wr(input logic [8:0] idx, input logic [7:0] d, input logic [2:0] p = PID);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= {p, idx};
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [8:0] idx, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= {PID, idx};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Register bit levels expected from the shadow copy
    function automatic logic [8:0] lv_exp();
        return {cfg[0][0], cfg[0][1], cfg[1][0], cfg[1][4], cfg[1][6], ~cfg[1][7],
            cfg[3][3], cfg[3][0], cfg[2][7]};
    endfunction

    // All-ones in NRZ format: positive high, negative low on every sample
    task automatic line_chk;
        repeat (300) @(posedge sys_clk);
        repeat (16)
        begin
            repeat (8) @(posedge sys_clk);
            #1 chk("line", {line_out_positive, line_out_negative}, 2'b10);
        end
    endtask

    // Look for the channel block output over more than one frame
    task automatic hunt(output logic seen);
        seen = 1'b0;
        repeat (3000)
        begin
            @(posedge sys_clk);
            #1 if (tx_channel_block_out === 1'b1) seen = 1'b1;
        end
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cut a hang short
    initial
    begin
        #400000;
        mismatches++;
        print_verdict;
    end

    initial
    begin
        reset_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {rx_alarm_in, status_irq_in} = '0;
        mismatches = 0;
        n_compared = 0;
        v = 8'($urandom(32'h1a30));
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Reset values
        for (int k = 0; k < 4; k++)
        begin
            rd(IDX[k], rd_v);
            chk("reset", rd_v, 9'h000);
            cfg[k] = 8'h00;
        end
        // Random writes, unused bits kept zero, both auto alarms never together
        for (int i = 0; i < 24; i++)
        begin
            v = 8'($urandom) & MSK[i % 4];
            if (i % 4 == 2 && v[6])
                v[5] = 1'b0;
            if (i % 4 == 1 && v[4])
                v[7] = 1'b0;
            wr(IDX[i % 4], v);
            cfg[i % 4] = v;
            rd(IDX[i % 4], rd_v);
            chk("readback", rd_v, v);
            chk("levels", {line_standard_e1, processor_reset, crc_gen_active, si_from_regs,
                ts16_from_regs, ts0_internal, mf_ref_system, crc_recalc_active,
                auto_ebit_active}, lv_exp());
            @(posedge sys_clk);
            status_irq_in <= 3'($urandom);
            rd(e1tx_pkg::REG_INT_SUMMARY, rd_v);
            chk("summary", rd_v, {6'h00, status_irq_in});
        end
        // Another port's window and read-only or unmapped places
        wr(IDX[1], 8'h5a, PID + 3'h1);
        rd(IDX[1], rd_v);
        chk("port", rd_v, cfg[1]);
        rd(9'h190, rd_v);
        chk("unmapped", rd_v, 9'h000);
        wr(e1tx_pkg::REG_INT_SUMMARY, 8'hff);
        status_irq_in <= 3'h0;
        rd(e1tx_pkg::REG_INT_SUMMARY, rd_v);
        chk("summary clear", rd_v, 9'h000);
        // Soft reset pulse, then NRZ with the alarm bit, then start
        wr(IDX[0], 8'h02);
        wr(IDX[0], 8'h00);
        wr(IDX[3], 8'h80);
        wr(IDX[2], 8'h00);
        wr(IDX[1], 8'h02);
        wr(IDX[0], 8'hc1);
        line_chk;
        // Automatic all-ones on receive loss of framing
        wr(IDX[1], 8'h00);
        rx_alarm_in <= 4'b1000;
        wr(IDX[2], 8'h40);
        line_chk;
        // Automatic remote alarm follows loss of signal
        @(posedge sys_clk);
        rx_alarm_in <= 4'b0011;
        wr(IDX[2], 8'h20);
        repeat (50) @(posedge sys_clk);
        #1 chk("remote on", send_remote_alarm, 9'h001);
        @(posedge sys_clk);
        rx_alarm_in <= 4'b0001;
        repeat (50) @(posedge sys_clk);
        #1 chk("remote off", send_remote_alarm, 9'h000);
        // With CRC-4 on, a missing multiframe sync raises the alarm after the short timeout
        wr(IDX[1], 8'h01);
        rx_alarm_in <= 4'b1000;
        repeat (20) @(posedge sys_clk);
        rx_alarm_in <= 4'b0000;
        repeat (100) @(posedge sys_clk);
        #1 chk("crc wait", send_remote_alarm, 9'h000);
        repeat (150) @(posedge sys_clk);
        #1 chk("crc lost", send_remote_alarm, 9'h001);
        // Channel 26 block output forced only with the option set
        wr(IDX[1], 8'h20);
        hunt(hit);
        chk("block on", hit, 9'h001);
        wr(IDX[1], 8'h00);
        repeat (10) @(posedge sys_clk);
        hunt(hit);
        chk("block off", hit, 9'h000);
        print_verdict;
    end
endmodule
